/* pkg/dacreg_pkg.sv */
// Purpose: Shared constants and types for the dual converter register bank
// Assumes: 8-bit registers, 5-bit register addresses
// Notes:   Defaults of registers outside this bank's detail are plain zero
package dacreg_pkg;

    localparam int unsigned  DATA_W        = 8;
    localparam int unsigned  ADDR_W        = 5;

    localparam logic [4:0]   ADDR_PORT_CTL = 5'h00;
    localparam logic [4:0]   ADDR_INTERP   = 5'h01;
    localparam logic [4:0]   ADDR_FMT      = 5'h02;
    localparam logic [4:0]   ADDR_CLKOUT   = 5'h03;
    localparam logic [4:0]   ADDR_PLL      = 5'h04;
    localparam logic [4:0]   ADDR_I_FINE   = 5'h05;
    localparam logic [4:0]   ADDR_I_COARSE = 5'h06;
    localparam logic [4:0]   ADDR_I_OFSH   = 5'h07;
    localparam logic [4:0]   ADDR_I_OFSL   = 5'h08;
    localparam logic [4:0]   ADDR_Q_FINE   = 5'h09;
    localparam logic [4:0]   ADDR_Q_COARSE = 5'h0A;
    localparam logic [4:0]   ADDR_Q_OFSH   = 5'h0B;
    localparam logic [4:0]   ADDR_Q_OFSL   = 5'h0C;
    localparam logic [4:0]   ADDR_VERSION  = 5'h0D;

    // Bit positions in the port/reset/power register
    localparam int unsigned  BIT_SDIO_BIDIR = 7;
    localparam int unsigned  BIT_LSB_FIRST  = 6;
    localparam int unsigned  BIT_SW_RESET   = 5;
    localparam int unsigned  BIT_SLEEP      = 4;
    localparam int unsigned  BIT_POWER_DOWN = 3;
    localparam int unsigned  BIT_ONE_RES    = 2;
    localparam int unsigned  BIT_PLL_LOCK   = 1;

    // Interpolation rate field position and offset direction bit
    localparam int unsigned  INTERP_LSB     = 6;
    localparam int unsigned  OFS_DIR_BIT    = 7;

    // Writable masks per register
    localparam logic [7:0]   MASK_PORT_CTL  = 8'hDC;
    localparam logic [7:0]   MASK_FULL      = 8'hFF;
    localparam logic [7:0]   MASK_COARSE    = 8'h0F;
    localparam logic [7:0]   MASK_OFSL      = 8'h83;
    localparam logic [7:0]   MASK_CLKOUT    = 8'h83;
    localparam logic [7:0]   MASK_PLL       = 8'hC7;
    localparam logic [7:0]   MASK_FMT       = 8'hF7;
    localparam logic [7:0]   MASK_VERSION   = 8'h0F;

    // Reset values
    localparam logic [7:0]   RST_ZERO       = 8'h00;
    localparam logic [7:0]   RST_INTERP     = 8'h04;

    // Serial frame
    localparam int unsigned  INSTR_BITS     = 8;
    localparam int unsigned  INSTR_READ_BIT = 7;

    typedef struct packed {
        logic [7:0] fineGain;
        logic [3:0] coarseGain;
        logic [9:0] offsetCurrent;
        logic       offsetOnComplementary;
    } dacreg_chan_t;

    typedef struct packed {
        logic       sleepOutputs;
        logic       powerDown;
        logic       referenceResistorMode;
        logic [1:0] interpRate;
        logic       lsbFirst;
        logic       sdioBidir;
    } dacreg_mode_t;

endpackage

/* design/dacreg_shifter.sv */
// Purpose: Bit-order aware serial shifter for one byte
// Assumes: One bit per shift pulse, same clock as the bank
// Notes:   Byte completes after eight shifts; counter restarts on clear
`timescale 1ns/1ps
`default_nettype none
module dacreg_shifter
    import dacreg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clear,
    input  wire logic              shift,
    input  wire logic              lsbFirst,
    input  wire logic              bitIn,
    output logic [DATA_W-1:0]      byteOut,
    output logic                   byteDone
);
    logic [DATA_W-1:0] shift_r;
    logic [2:0]        count_r;

    always_ff @(posedge clk)
    begin
        if (!nrst || clear)
        begin
            shift_r <= 8'h00;
            count_r <= 3'h0;
        end
        else if (shift)
        begin
            // Either end feeds in, so both orders land aligned
            if (lsbFirst)
                shift_r <= {bitIn, shift_r[7:1]};
            else
                shift_r <= {shift_r[6:0], bitIn};
            count_r <= count_r + 3'h1;
        end
    end

    always_comb
    begin
        if (lsbFirst)
            byteOut = {bitIn, shift_r[7:1]};
        else
            byteOut = {shift_r[6:0], bitIn};
        byteDone = shift && (count_r == 3'h7);
    end
endmodule
`default_nettype wire

/* design/dacreg_bank.sv */
// Purpose: Control register bank of a dual interpolating converter
// Assumes: Serial port pins sampled on clk; hardware reset pin active high
// Notes:   Instruction byte: bit 7 read, bits 4..0 address; one data byte
//
// Function
// - SDIO drives reads only when bidirectional
// - Bit order follows LSB-first control bit
// - Software reset restores defaults, restarts chip
// - Software reset bit always reads zero
// - Software reset spares register 00h
// - Hardware reset pin restores every register's default, 00h included (00h to 0Ch)
// - Sleep bit turns off output currents
// - Power-down stops all but serial port
// - Bit 2 selects one or two resistors
// - Bit 1 reads live PLL lock while 04h bit 7 is set, else zero
// - 01h bits 7:6 select interpolation rate
// - Fine gain bytes at 05h and 09h
// - Coarse gain nibbles at 06h and 0Ah
// - I offset from 07h and 08h[1:0]
// - Q offset from 0Bh and 0Ch[1:0]
// - 08h bit 7 steers I offset
// - 0Ch bit 7 steers Q offset
`timescale 1ns/1ps
`default_nettype none
module dacreg_bank
    import dacreg_pkg::*;
#(
    parameter logic [3:0] VERSION = 4'h3  // Arbitrary value
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              resetPin,
    input  wire logic              csPin_n,
    input  wire logic              sclkPin,
    input  wire logic              sdioIn,
    output logic                   sdioOut,
    output logic                   sdioOe,
    input  wire logic              pllLocked,
    output logic                   chipRestart,
    output logic                   coreEnable,
    output dacreg_mode_t           mode,
    output dacreg_chan_t           inPhase,
    output dacreg_chan_t           quadrature,
    output logic [7:0]             fmtCtl,
    output logic [7:0]             clkOutCtl,
    output logic [7:0]             pllCtl
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_DONE  = 4'b1000
    } dacreg_state_t;

    // Three-stage input sync; change taken when stages 2 and 3 agree
    logic [2:0] csSync_r;
    logic [2:0] sclkSync_r;
    logic [2:0] sdioSync_r;
    logic [2:0] rstSync_r;
    logic       csStable_r;
    logic       sclkStable_r;
    logic       sdioStable_r;
    logic       rstStable_r;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            csSync_r   <= 3'h7;
            sclkSync_r <= 3'h0;
            sdioSync_r <= 3'h0;
            rstSync_r  <= 3'h0;
        end
        else
        begin
            csSync_r   <= {csSync_r[1:0], csPin_n};
            sclkSync_r <= {sclkSync_r[1:0], sclkPin};
            sdioSync_r <= {sdioSync_r[1:0], sdioIn};
            rstSync_r  <= {rstSync_r[1:0], resetPin};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            csStable_r   <= 1'b1;
            sclkStable_r <= 1'b0;
            sdioStable_r <= 1'b0;
            rstStable_r  <= 1'b0;
        end
        else
        begin
            if (csSync_r[1] == csSync_r[2])
                csStable_r <= csSync_r[2];
            if (sclkSync_r[1] == sclkSync_r[2])
                sclkStable_r <= sclkSync_r[2];
            if (sdioSync_r[1] == sdioSync_r[2])
                sdioStable_r <= sdioSync_r[2];
            if (rstSync_r[1] == rstSync_r[2])
                rstStable_r <= rstSync_r[2];
        end
    end

    logic sclkPrev_r;
    logic sclkRise;
    logic sclkFall;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            sclkPrev_r <= 1'b0;
        else
            sclkPrev_r <= sclkStable_r;
    end

    assign sclkRise = sclkStable_r && !sclkPrev_r;
    assign sclkFall = !sclkStable_r && sclkPrev_r;

    // Registers
    logic [7:0]    portCtl_r;
    logic [7:0]    interp_r;
    logic [7:0]    fmt_r;
    logic [7:0]    clkOut_r;
    logic [7:0]    pll_r;
    logic [7:0]    iFine_r;
    logic [7:0]    iCoarse_r;
    logic [7:0]    iOfsH_r;
    logic [7:0]    iOfsL_r;
    logic [7:0]    qFine_r;
    logic [7:0]    qCoarse_r;
    logic [7:0]    qOfsH_r;
    logic [7:0]    qOfsL_r;

    dacreg_state_t state_r;
    dacreg_state_t state_nxt;
    logic          isRead_r;
    logic [4:0]    addr_r;
    logic [7:0]    readByte_r;
    logic          sdioOut_r;
    logic          swReset_r;

    logic [7:0]    rxByte;
    logic          rxDone;
    logic          shiftClear;
    logic          writeStrobe;
    logic          hwReset;

    assign hwReset    = rstStable_r;
    assign shiftClear = csStable_r || (state_r == ST_DONE);

    dacreg_shifter u_shifter (
        .clk      (clk),
        .nrst     (nrst),
        .clear    (shiftClear),
        .shift    (sclkRise && !csStable_r),
        .lsbFirst (portCtl_r[BIT_LSB_FIRST]),
        .bitIn    (sdioStable_r),
        .byteOut  (rxByte),
        .byteDone (rxDone)
    );

    function automatic logic [7:0] readMux(input logic [4:0] a);
        case (a)
            ADDR_PORT_CTL: readMux = (portCtl_r & MASK_PORT_CTL)
                                     | ({7'h00, pllLocked && pll_r[7]} << BIT_PLL_LOCK);
            ADDR_INTERP:   readMux = interp_r;
            ADDR_FMT:      readMux = fmt_r;
            ADDR_CLKOUT:   readMux = clkOut_r;
            ADDR_PLL:      readMux = pll_r;
            ADDR_I_FINE:   readMux = iFine_r;
            ADDR_I_COARSE: readMux = iCoarse_r;
            ADDR_I_OFSH:   readMux = iOfsH_r;
            ADDR_I_OFSL:   readMux = iOfsL_r;
            ADDR_Q_FINE:   readMux = qFine_r;
            ADDR_Q_COARSE: readMux = qCoarse_r;
            ADDR_Q_OFSH:   readMux = qOfsH_r;
            ADDR_Q_OFSL:   readMux = qOfsL_r;
            ADDR_VERSION:  readMux = {4'h0, VERSION} & MASK_VERSION;
            default:       readMux = 8'h00;
        endcase
    endfunction

    // Frame sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (!csStable_r) state_nxt = ST_INSTR;
            ST_INSTR: if (rxDone) state_nxt = ST_DATA;
            // Ends on 16th rise so the last read bit stands until sampled
            ST_DATA:  if (rxDone) state_nxt = ST_DONE;
            ST_DONE:  state_nxt = ST_DONE;
            default:  state_nxt = ST_IDLE;
        endcase
        if (csStable_r)
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset)
        begin
            isRead_r <= 1'b0;
            addr_r   <= 5'h00;
        end
        else if (state_r == ST_INSTR && rxDone)
        begin
            isRead_r <= rxByte[INSTR_READ_BIT];
            addr_r   <= rxByte[4:0];
        end
    end

    assign writeStrobe = (state_r == ST_DATA) && rxDone && !isRead_r;

    // Read data shifted out on falling edges so host samples on rising
    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset || state_r != ST_DATA)
        begin
            readByte_r <= (state_r == ST_INSTR && rxDone) ? readMux(rxByte[4:0]) : 8'h00;
            sdioOut_r  <= 1'b0;
        end
        else if (isRead_r && sclkFall)
        begin
            if (portCtl_r[BIT_LSB_FIRST])
            begin
                sdioOut_r  <= readByte_r[0];
                readByte_r <= {1'b0, readByte_r[7:1]};
            end
            else
            begin
                sdioOut_r  <= readByte_r[7];
                readByte_r <= {readByte_r[6:0], 1'b0};
            end
        end
    end

    // Only a bidirectional port turns the pin around
    assign sdioOe  = (state_r == ST_DATA) && isRead_r && portCtl_r[BIT_SDIO_BIDIR];
    assign sdioOut = sdioOut_r;

    // Register 00h survives the software reset
    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset)
            portCtl_r <= RST_ZERO;
        else if (writeStrobe && addr_r == ADDR_PORT_CTL)
            portCtl_r <= rxByte & MASK_PORT_CTL;
    end

    // One-cycle pulse; the stored bit never holds a one
    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset)
            swReset_r <= 1'b0;
        else
            swReset_r <= writeStrobe && addr_r == ADDR_PORT_CTL && rxByte[BIT_SW_RESET];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst || hwReset || swReset_r)
        begin
            interp_r  <= RST_INTERP;
            fmt_r     <= RST_ZERO;
            clkOut_r  <= RST_ZERO;
            pll_r     <= RST_ZERO;
            iFine_r   <= RST_ZERO;
            iCoarse_r <= RST_ZERO;
            iOfsH_r   <= RST_ZERO;
            iOfsL_r   <= RST_ZERO;
            qFine_r   <= RST_ZERO;
            qCoarse_r <= RST_ZERO;
            qOfsH_r   <= RST_ZERO;
            qOfsL_r   <= RST_ZERO;
        end
        else if (writeStrobe)
        begin
            case (addr_r)
                ADDR_INTERP:   interp_r  <= rxByte & MASK_FULL;
                ADDR_FMT:      fmt_r     <= rxByte & MASK_FMT;
                ADDR_CLKOUT:   clkOut_r  <= rxByte & MASK_CLKOUT;
                ADDR_PLL:      pll_r     <= rxByte & MASK_PLL;
                ADDR_I_FINE:   iFine_r   <= rxByte;
                ADDR_I_COARSE: iCoarse_r <= rxByte & MASK_COARSE;
                ADDR_I_OFSH:   iOfsH_r   <= rxByte;
                ADDR_I_OFSL:   iOfsL_r   <= rxByte & MASK_OFSL;
                ADDR_Q_FINE:   qFine_r   <= rxByte;
                ADDR_Q_COARSE: qCoarse_r <= rxByte & MASK_COARSE;
                ADDR_Q_OFSH:   qOfsH_r   <= rxByte;
                ADDR_Q_OFSL:   qOfsL_r   <= rxByte & MASK_OFSL;
                default:       ; // Version and unmapped ignore writes
            endcase
        end
    end

    // Control outputs from flops
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            chipRestart <= 1'b0;
            coreEnable  <= 1'b0;
            mode        <= '0;
            inPhase     <= '0;
            quadrature  <= '0;
            fmtCtl      <= 8'h00;
            clkOutCtl   <= 8'h00;
            pllCtl      <= 8'h00;
        end
        else
        begin
            chipRestart                <= swReset_r || hwReset;
            coreEnable                 <= !portCtl_r[BIT_POWER_DOWN];
            mode.sleepOutputs          <= portCtl_r[BIT_SLEEP];
            mode.powerDown             <= portCtl_r[BIT_POWER_DOWN];
            mode.referenceResistorMode <= portCtl_r[BIT_ONE_RES];
            mode.interpRate            <= interp_r[INTERP_LSB+:2];
            mode.lsbFirst              <= portCtl_r[BIT_LSB_FIRST];
            mode.sdioBidir             <= portCtl_r[BIT_SDIO_BIDIR];
            inPhase.fineGain           <= iFine_r;
            inPhase.coarseGain         <= iCoarse_r[3:0];
            inPhase.offsetCurrent      <= {iOfsH_r, iOfsL_r[1:0]};
            inPhase.offsetOnComplementary <= iOfsL_r[OFS_DIR_BIT];
            quadrature.fineGain        <= qFine_r;
            quadrature.coarseGain      <= qCoarse_r[3:0];
            quadrature.offsetCurrent   <= {qOfsH_r, qOfsL_r[1:0]};
            quadrature.offsetOnComplementary <= qOfsL_r[OFS_DIR_BIT];
            fmtCtl                     <= fmt_r;
            clkOutCtl                  <= clkOut_r;
            pllCtl                     <= pll_r;
        end
    end
endmodule
`default_nettype wire

/* tb/dacreg_host.sv */
// Purpose: Host model driving the serial register port
// Assumes: sclk idles low; HALF clocks per sclk phase
// Notes:   Released sdio toggles so a stale bit never reads valid
`timescale 1ns/1ps
`default_nettype none
module dacreg_host
    import dacreg_pkg::*;
#(
    parameter int HALF = 8
)
(
    input  wire logic clk,
    input  wire logic sdioOut,
    input  wire logic sdioOe,
    output logic      csPin_n,
    output logic      sclkPin,
    output logic      sdioIn
);
    logic hostBit;

    // Wire level from both drivers
    assign sdioIn = sdioOe ? sdioOut : hostBit;

    initial
    begin
        csPin_n = 1'b1;
        sclkPin = 1'b0;
        hostBit = 1'b0;
    end

    task automatic frame(
        input  logic       rd,
        input  logic       lsb,
        input  logic [4:0] a,
        input  logic [7:0] d,
        output logic [7:0] q
    );
        logic [7:0] b;
        int         j;
        q = 8'h00;
        @(posedge clk);
        csPin_n <= 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            b = (k < 8) ? {rd, 2'b00, a} : d;
            j = lsb ? k % 8 : 7 - k % 8;
            hostBit <= (rd && k >= 8) ? ~hostBit : b[j];
            repeat (HALF) @(posedge clk);
            if (rd && k >= 8)
                q[j] = sdioOut;
            sclkPin <= 1'b1;
            repeat (HALF) @(posedge clk);
            sclkPin <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        csPin_n <= 1'b1;
        hostBit <= ~hostBit;
        // Gap lets the write land before the next frame
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* tb/dacreg_bank_checker.sv */
// Purpose: Port-level checks of the register bank
// Assumes: Hardware reset held at least 8 clocks
// Notes:   Sync latency of the pins is absorbed by the windows
`timescale 1ns/1ps
`default_nettype none
module dacreg_bank_checker
    import dacreg_pkg::*;
(
    input wire logic         clk,
    input wire logic         nrst,
    input wire logic         resetPin,
    input wire logic         csPin_n,
    input wire logic         sclkPin,
    input wire logic         sdioIn,
    input wire logic         sdioOut,
    input wire logic         sdioOe,
    input wire logic         pllLocked,
    input wire logic         chipRestart,
    input wire logic         coreEnable,
    input wire dacreg_mode_t mode,
    input wire dacreg_chan_t inPhase,
    input wire dacreg_chan_t quadrature,
    input wire logic [7:0]   fmtCtl,
    input wire logic [7:0]   clkOutCtl,
    input wire logic [7:0]   pllCtl
);
    logic [1:0] upCnt_r;
    logic       upOk;
    logic [4:0] portBits;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Outputs lag reset release; hold off core checks
    always_ff @(posedge clk)
    begin
        if (!nrst)
            upCnt_r <= 2'd0;
        else if (upCnt_r != 2'd3)
            upCnt_r <= upCnt_r + 2'd1;
    end
    assign upOk = upCnt_r == 2'd3;
    assign portBits = {mode.sdioBidir, mode.lsbFirst, mode.sleepOutputs,
                       mode.powerDown, mode.referenceResistorMode};

    sequence s_hw_held;
        resetPin [*8];
    endsequence
    sequence s_sw_pulse;
        !resetPin [*8] ##1 chipRestart;
    endsequence

    a_oe_bidir: assert property (sdioOe |-> mode.sdioBidir)
        else $error("sdio driven while input only");
    a_oe_idle: assert property (csPin_n [*6] |-> !sdioOe)
        else $error("sdio driven outside frame");
    a_hw_clear: assert property (s_hw_held |=> mode == '0 && inPhase == '0 && quadrature == '0)
        else $error("hardware reset left state");
    a_hw_restart: assert property (s_hw_held |-> chipRestart)
        else $error("no restart in hardware reset");
    a_sw_clear: assert property (s_sw_pulse |-> ##3 inPhase == '0 && quadrature == '0)
        else $error("software reset left channels");
    a_sw_keep: assert property (s_sw_pulse |=> $stable(portBits) [*3])
        else $error("software reset changed 00h");
    a_pulse_one: assert property (s_sw_pulse |=> !chipRestart)
        else $error("restart pulse too long");
    a_core_off: assert property (upOk && mode.powerDown && $past(mode.powerDown) |-> !coreEnable)
        else $error("core on in power-down");
    a_core_on: assert property (upOk && !chipRestart && !$past(chipRestart) && !mode.powerDown
                                && !$past(mode.powerDown) |-> coreEnable)
        else $error("core off while powered");
endmodule

bind dacreg_bank dacreg_bank_checker i_chk (
    .clk(clk), .nrst(nrst), .resetPin(resetPin), .csPin_n(csPin_n),
    .sclkPin(sclkPin), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .pllLocked(pllLocked), .chipRestart(chipRestart), .coreEnable(coreEnable),
    .mode(mode), .inPhase(inPhase), .quadrature(quadrature),
    .fmtCtl(fmtCtl), .clkOutCtl(clkOutCtl), .pllCtl(pllCtl)
);
`default_nettype wire

/* tb/dacreg_bank_test.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the serial port
// Notes:   Unmapped addresses are expected to read zero
`timescale 1ns/1ps
`default_nettype none
module dacreg_bank_test
    import dacreg_pkg::*;
;
    localparam logic [3:0] VER = 4'h5;  // Arbitrary value
    localparam logic [7:0] WV [8] = '{8'hA5, 8'hFF, 8'hC3, 8'hFF, 8'h5A, 8'hF6, 8'h3C, 8'h81};
    localparam logic [7:0] RV [8] = '{8'hA5, 8'h0F, 8'hC3, 8'h83, 8'h5A, 8'h06, 8'h3C, 8'h81};
    logic         clk, nrst, resetPin, pllLocked, lsb, oeSeen, rstSeen;
    logic         csPin_n, sclkPin, sdioIn, sdioOut, sdioOe, chipRestart, coreEnable;
    dacreg_mode_t mode;
    dacreg_chan_t inPhase, quadrature;
    logic [7:0]   fmtCtl, clkOutCtl, pllCtl;
    int           n_errors, comparisons, cyc;

    always #10 clk = ~clk;

    dacreg_bank #(.VERSION(VER)) i_dut (
        .clk(clk), .nrst(nrst), .resetPin(resetPin), .csPin_n(csPin_n),
        .sclkPin(sclkPin), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .pllLocked(pllLocked), .chipRestart(chipRestart), .coreEnable(coreEnable),
        .mode(mode), .inPhase(inPhase), .quadrature(quadrature),
        .fmtCtl(fmtCtl), .clkOutCtl(clkOutCtl), .pllCtl(pllCtl)
    );
    dacreg_host i_host (.clk(clk), .sdioOut(sdioOut), .sdioOe(sdioOe),
        .csPin_n(csPin_n), .sclkPin(sclkPin), .sdioIn(sdioIn));

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sdioOe)
            oeSeen <= 1'b1;
        if (chipRestart)
            rstSeen <= 1'b1;
        if (cyc == 40000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        #1;
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.frame(1'b0, lsb, a, d, q);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] e, input string m);
        logic [7:0] q;
        i_host.frame(1'b1, lsb, a, 8'h00, q);
        chk(q, e, m);
    endtask

    task automatic t_defaults;
        rdchk(5'h00, 8'h00, "00h");
        rdchk(5'h01, 8'h04, "01h");
        for (int a = 5; a < 13; a++)
            rdchk(5'(a), 8'h00, "chan");
        wr(5'h0D, 8'hFF);
        rdchk(5'h0D, {4'h0, VER}, "version");
        wr(5'h1F, 8'hFF);
        rdchk(5'h1F, 8'h00, "unmapped");
    endtask

    task automatic t_fields;
        for (int i = 0; i < 8; i++)
        begin
            wr(5'(i + 5), WV[i]);
            rdchk(5'(i + 5), RV[i], "field");
        end
        chk(inPhase, {8'hA5, 4'hF, 10'h30F, 1'b1}, "inPhase");
        chk(quadrature, {8'h5A, 4'h6, 10'h0F1, 1'b1}, "quad");
    endtask

    task automatic t_aux;
        wr(5'h02, 8'hFF);
        rdchk(5'h02, MASK_FMT, "fmt");
        wr(5'h03, 8'hFF);
        rdchk(5'h03, MASK_CLKOUT, "clkout");
        wr(5'h04, 8'h7F);
        rdchk(5'h04, 8'h47, "pll");
        chk({fmtCtl, clkOutCtl, pllCtl}, {MASK_FMT, MASK_CLKOUT, 8'h47}, "aux out");
        wr(5'h02, 8'h00);
        wr(5'h03, 8'h00);
        wr(5'h04, 8'h00);
    endtask

    task automatic t_mode;
        logic [7:0] v;
        for (int i = 0; i < 3; i++)
        begin
            v = 8'h10 >> i;
            wr(5'h00, v);
            chk({mode.sleepOutputs, mode.powerDown, mode.referenceResistorMode}, v[4:2], "mode");
            chk(coreEnable, !v[3], "core");
            rdchk(5'h00, v, "ctl");
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(5'h01, {r[1:0], 6'h04});
            chk(mode.interpRate, r[1:0], "rate");
        end
    endtask

    task automatic t_order;
        wr(5'h00, 8'h40);
        lsb = 1'b1;
        chk(mode.lsbFirst, 1'b1, "lsb");
        wr(5'h05, 8'h12);
        chk(inPhase.fineGain, 8'h12, "lsb data");
        oeSeen = 1'b0;
        rdchk(5'h05, 8'h12, "lsb rd");
        chk(oeSeen, 1'b0, "oe input");
        wr(5'h00, 8'hC0);
        oeSeen = 1'b0;
        rdchk(5'h05, 8'h12, "bidir rd");
        chk(oeSeen, 1'b1, "oe bidir");
        oeSeen = 1'b0;
        wr(5'h05, 8'h00);
        chk(oeSeen, 1'b0, "oe wr");
        wr(5'h00, 8'h00);
        lsb = 1'b0;
    endtask

    task automatic t_pll;
        wr(5'h04, 8'h80);
        @(posedge clk) pllLocked <= 1'b1;
        rdchk(5'h00, 8'h02, "locked");
        @(posedge clk) pllLocked <= 1'b0;
        rdchk(5'h00, 8'h00, "unlocked");
        wr(5'h04, 8'h00);
        @(posedge clk) pllLocked <= 1'b1;
        rdchk(5'h00, 8'h00, "pll off");
        @(posedge clk) pllLocked <= 1'b0;
    endtask

    task automatic t_swreset;
        wr(5'h00, 8'h14);
        wr(5'h05, 8'h77);
        wr(5'h01, 8'h40);
        rstSeen = 1'b0;
        wr(5'h00, 8'h34);
        chk(rstSeen, 1'b1, "restart");
        rdchk(5'h00, 8'h14, "keep 00h");
        rdchk(5'h05, 8'h00, "fine def");
        rdchk(5'h01, 8'h04, "rate def");
    endtask

    task automatic t_hwreset;
        wr(5'h05, 8'h55);
        @(posedge clk) resetPin <= 1'b1;
        repeat (12) @(posedge clk);
        resetPin <= 1'b0;
        repeat (8) @(posedge clk);
        chk(mode, 7'h00, "mode");
        rdchk(5'h00, 8'h00, "00h");
        rdchk(5'h05, 8'h00, "fine");
    endtask

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        resetPin = 1'b0;
        pllLocked = 1'b0;
        lsb = 1'b0;
        oeSeen = 1'b0;
        rstSeen = 1'b0;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        t_defaults();
        t_fields();
        t_aux();
        t_mode();
        t_order();
        t_pll();
        t_swreset();
        t_hwreset();
        summarize();
    end
endmodule
`default_nettype wire
